// ===== inc/scc_cfg.svh
// Constants of the serial channel common configuration register bank:
// addresses, field positions, reset values and bus response codes.
// Assumes inclusion by bare name from files under src/ and bench/.
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// ==========================================================================
// Register byte addresses
`define SCC_ADDR_CH_AC    32'h0003_0024
`define SCC_ADDR_CH_AD    32'h0003_0034
`define SCC_ADDR_CH_BC    32'h0003_0124
`define SCC_ADDR_CH_BD    32'h0003_0134
`define SCC_ADDR_BLK_A    32'h0003_0000
`define SCC_ADDR_BLK_B    32'h0003_0100
`define SCC_ADDR_STATUS   32'h0003_0200
`define SCC_ADDR_IRQ_EN   32'h0003_0204

// ==========================================================================
// Channel configuration register fields
`define SCC_CH_RSVD_BIT   0
`define SCC_CH_ALARM_BIT  1
`define SCC_CH_SRST_BIT   2
`define SCC_CH_TEST_BIT   7
`define SCC_CH_WMASK      8'h87
`define SCC_CH_RESET      8'h02

// ==========================================================================
// Block control register fields
`define SCC_BLK_ALARM_BIT 1
`define SCC_BLK_SRST_BIT  2
`define SCC_BLK_TEST_BIT  7
`define SCC_BLK_PAT_LSB   8
`define SCC_BLK_PAT_MSB   12
`define SCC_BLK_WMASK     13'h1f86
`define SCC_BLK_RESET     13'h0002

// ==========================================================================
// Interrupt registers and bus responses
`define SCC_STAT_RESET    4'h0
`define SCC_IRQ_EN_RESET  4'h0
`define SCC_RESP_OKAY     2'h0
`define SCC_RESP_SLVERR   2'h2

`endif

// ===== inc/scc_pkg.sv
// Types shared by the serial channel common configuration design.
// Assumes nothing of its surroundings.
package scc_pkg;

    // ======================================================================
    // Bus channel state, one instance for writes and one for reads
    typedef enum logic [1:0] {
        SCC_IDLE = 2'h0,
        SCC_RESP = 2'h1
    } scc_bus_state_t;

endpackage

// ===== src/scc_chan.sv
// One channel's effective controls: reset, test mode and alarm gating.
// Assumes configuration and block bits come from flops on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "scc_cfg.svh"

module scc_chan (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_cfg,
    input  wire logic       i_blk_alarm_block,
    input  wire logic       i_blk_soft_reset,
    input  wire logic       i_blk_test_override,
    input  wire logic       i_alarm,
    output logic            o_alarm_pass,
    output logic            o_chan_reset,
    output logic            o_chan_test
);

    logic rst_q;
    logic rst_d;
    logic test_q;
    logic test_d;

    // ======================================================================
    // Combined controls
    assign rst_d = i_cfg[`SCC_CH_SRST_BIT] | i_blk_soft_reset;
    assign test_d = i_blk_test_override | i_cfg[`SCC_CH_TEST_BIT];
    assign o_alarm_pass = i_alarm & ~i_cfg[`SCC_CH_ALARM_BIT]
                          & ~i_blk_alarm_block;

    // ======================================================================
    // Channel held in reset during device reset as well
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rst_q  <= 1'b1;
            test_q <= 1'b0;
        end else begin
            rst_q  <= rst_d;
            test_q <= test_d;
        end
    end

    assign o_chan_reset = rst_q;
    assign o_chan_test = test_q;

endmodule
`default_nettype wire

// ===== src/scc_top.sv
// Common configuration register bank for four serial channels in two
// blocks, reached over AXI4-Lite, with alarm interrupt gathering.
// Assumes alarm inputs are synchronous to I_CLK; one clock, sync reset.
//
// Behaviour
// - Per channel one 8-bit R/W register: 30024, 30034, 30124, 30134.
// - Bit 0 is reserved, resets to zero; software writes zero.
// - Channel alarm block bit set stops all that channel's alarm interrupts.
// - Channel alarm block overrides the individual per-alarm mask bits.
// - Channel alarm block bit resets to one.
// - Channel soft reset holds channel logic in reset, configuration kept.
// - Soft reset is not self-clearing; software sets then clears it.
// - Channel soft reset bit resets to zero.
// - Channel test select bit 7 puts channel in test; block picks pattern.
// - Block test override low: each channel follows its own test bit.
// - Block test override high: all channels of the block in test.
// - Channel test select bit resets to zero.
// - Block alarm block, reset to one, masks both channels and overrides.
// - Block soft reset resets both channels, overriding channel bits.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "scc_cfg.svh"

module scc_top (
    input  wire logic        I_CLK,
    input  wire logic        I_RST_B,
    input  wire logic [31:0] I_AWADDR,
    input  wire logic [2:0]  I_AWPROT,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic [31:0] I_ARADDR,
    input  wire logic [2:0]  I_ARPROT,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    input  wire logic [3:0]  I_ALARM,
    output logic [3:0]       O_CHAN_RESET,
    output logic [3:0]       O_CHAN_TEST,
    output logic [4:0]       O_TEST_PATTERN_SELECT_A,
    output logic [4:0]       O_TEST_PATTERN_SELECT_B,
    output logic             O_IRQ
);

    // ======================================================================
    // Declarations
    scc_pkg::scc_bus_state_t wr_st_q;
    scc_pkg::scc_bus_state_t wr_st_d;
    scc_pkg::scc_bus_state_t rd_st_q;
    scc_pkg::scc_bus_state_t rd_st_d;

    logic [7:0]  cfg_q [0:3];
    logic [12:0] blk_q [0:1];
    logic [3:0]  stat_q;
    logic [3:0]  stat_d;
    logic [3:0]  irq_en_q;
    logic        irq_q;
    logic [1:0]  bresp_q;
    logic [1:0]  bresp_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;

    logic        wr_go;
    logic        rd_go;
    logic [3:0]  wr_hit_ch;
    logic [1:0]  wr_hit_blk;
    logic        wr_hit_stat;
    logic        wr_hit_en;
    logic        wr_mapped;
    logic [3:0]  rd_hit_ch;
    logic [1:0]  rd_hit_blk;
    logic        rd_hit_stat;
    logic        rd_hit_en;
    logic        rd_mapped;
    logic [3:0]  stat_clr;
    logic [3:0]  alarm_pass;
    logic [12:0] blk_wdata;
    logic [12:0] blk_wen;
    logic [7:0]  ch_wdata;

    // ======================================================================
    // Write address decode
    assign wr_hit_ch[0] = (I_AWADDR == `SCC_ADDR_CH_AC);
    assign wr_hit_ch[1] = (I_AWADDR == `SCC_ADDR_CH_AD);
    assign wr_hit_ch[2] = (I_AWADDR == `SCC_ADDR_CH_BC);
    assign wr_hit_ch[3] = (I_AWADDR == `SCC_ADDR_CH_BD);
    assign wr_hit_blk[0] = (I_AWADDR == `SCC_ADDR_BLK_A);
    assign wr_hit_blk[1] = (I_AWADDR == `SCC_ADDR_BLK_B);
    assign wr_hit_stat = (I_AWADDR == `SCC_ADDR_STATUS);
    assign wr_hit_en = (I_AWADDR == `SCC_ADDR_IRQ_EN);
    assign wr_mapped = (|wr_hit_ch) | (|wr_hit_blk) | wr_hit_stat
                       | wr_hit_en;

    // ======================================================================
    // Read address decode
    assign rd_hit_ch[0] = (I_ARADDR == `SCC_ADDR_CH_AC);
    assign rd_hit_ch[1] = (I_ARADDR == `SCC_ADDR_CH_AD);
    assign rd_hit_ch[2] = (I_ARADDR == `SCC_ADDR_CH_BC);
    assign rd_hit_ch[3] = (I_ARADDR == `SCC_ADDR_CH_BD);
    assign rd_hit_blk[0] = (I_ARADDR == `SCC_ADDR_BLK_A);
    assign rd_hit_blk[1] = (I_ARADDR == `SCC_ADDR_BLK_B);
    assign rd_hit_stat = (I_ARADDR == `SCC_ADDR_STATUS);
    assign rd_hit_en = (I_ARADDR == `SCC_ADDR_IRQ_EN);
    assign rd_mapped = (|rd_hit_ch) | (|rd_hit_blk) | rd_hit_stat
                       | rd_hit_en;

    // ======================================================================
    // Write channel handshake: address and data taken together
    assign wr_go = I_AWVALID & I_WVALID & (wr_st_q == scc_pkg::SCC_IDLE);
    assign O_AWREADY = wr_go;
    assign O_WREADY = wr_go;
    assign bresp_d = wr_mapped ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;

    always_comb begin
        wr_st_d = wr_st_q;
        unique case (wr_st_q)
            scc_pkg::SCC_IDLE: begin
                if (wr_go) begin
                    wr_st_d = scc_pkg::SCC_RESP;
                end
            end
            scc_pkg::SCC_RESP: begin
                if (I_BREADY) begin
                    wr_st_d = scc_pkg::SCC_IDLE;
                end
            end
            default: begin
                wr_st_d = scc_pkg::SCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            wr_st_q <= scc_pkg::SCC_IDLE;
            bresp_q <= `SCC_RESP_OKAY;
        end else begin
            wr_st_q <= wr_st_d;
            if (wr_go) begin
                bresp_q <= bresp_d;
            end
        end
    end

    assign O_BVALID = (wr_st_q == scc_pkg::SCC_RESP);
    assign O_BRESP = bresp_q;

    // ======================================================================
    // Channel configuration registers, unused bits never stored
    assign ch_wdata = I_WDATA[7:0] & `SCC_CH_WMASK;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            for (int i = 0; i < 4; i++) begin
                cfg_q[i] <= `SCC_CH_RESET;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_go && wr_hit_ch[i] && I_WSTRB[0]) begin
                    cfg_q[i] <= ch_wdata;
                end
            end
        end
    end

    // ======================================================================
    // Block control registers, lanes 0 and 1
    assign blk_wen = {{5{I_WSTRB[1]}}, {8{I_WSTRB[0]}}} & `SCC_BLK_WMASK;
    assign blk_wdata = I_WDATA[12:0];

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            for (int b = 0; b < 2; b++) begin
                blk_q[b] <= `SCC_BLK_RESET;
            end
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (wr_go && wr_hit_blk[b]) begin
                    blk_q[b] <= (blk_q[b] & ~blk_wen)
                                | (blk_wdata & blk_wen);
                end
            end
        end
    end

    assign O_TEST_PATTERN_SELECT_A =
        blk_q[0][`SCC_BLK_PAT_MSB:`SCC_BLK_PAT_LSB];
    assign O_TEST_PATTERN_SELECT_B =
        blk_q[1][`SCC_BLK_PAT_MSB:`SCC_BLK_PAT_LSB];

    // ======================================================================
    // Per-channel controls; channels 0,1 in block A and 2,3 in block B
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_chan
            scc_chan u_chan (
                .i_clk               (I_CLK),
                .i_rst_b             (I_RST_B),
                .i_cfg               (cfg_q[g]),
                .i_blk_alarm_block   (blk_q[g/2][`SCC_BLK_ALARM_BIT]),
                .i_blk_soft_reset    (blk_q[g/2][`SCC_BLK_SRST_BIT]),
                .i_blk_test_override (blk_q[g/2][`SCC_BLK_TEST_BIT]),
                .i_alarm             (I_ALARM[g]),
                .o_alarm_pass        (alarm_pass[g]),
                .o_chan_reset        (O_CHAN_RESET[g]),
                .o_chan_test         (O_CHAN_TEST[g])
            );
        end
    endgenerate

    // ======================================================================
    // Alarm status, write one to clear; a new alarm wins over the clear
    assign stat_clr = (wr_go && wr_hit_stat && I_WSTRB[0]) ?
                      I_WDATA[3:0] : 4'h0;
    assign stat_d = (stat_q & ~stat_clr) | alarm_pass;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            stat_q   <= `SCC_STAT_RESET;
            irq_en_q <= `SCC_IRQ_EN_RESET;
            irq_q    <= 1'b0;
        end else begin
            stat_q <= stat_d;
            if (wr_go && wr_hit_en && I_WSTRB[0]) begin
                irq_en_q <= I_WDATA[3:0];
            end
            irq_q <= |(stat_q & irq_en_q);
        end
    end

    assign O_IRQ = irq_q;

    // ======================================================================
    // Read data selection
    always_comb begin
        rdata_d = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            if (rd_hit_ch[i]) begin
                rdata_d = {24'h00_0000, cfg_q[i]};
            end
        end
        for (int b = 0; b < 2; b++) begin
            if (rd_hit_blk[b]) begin
                rdata_d = {19'h0_0000, blk_q[b]};
            end
        end
        if (rd_hit_stat) begin
            rdata_d = {28'h000_0000, stat_q};
        end
        if (rd_hit_en) begin
            rdata_d = {28'h000_0000, irq_en_q};
        end
    end

    assign rresp_d = rd_mapped ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;

    // ======================================================================
    // Read channel handshake
    assign rd_go = I_ARVALID & (rd_st_q == scc_pkg::SCC_IDLE);
    assign O_ARREADY = (rd_st_q == scc_pkg::SCC_IDLE);

    always_comb begin
        rd_st_d = rd_st_q;
        unique case (rd_st_q)
            scc_pkg::SCC_IDLE: begin
                if (rd_go) begin
                    rd_st_d = scc_pkg::SCC_RESP;
                end
            end
            scc_pkg::SCC_RESP: begin
                if (I_RREADY) begin
                    rd_st_d = scc_pkg::SCC_IDLE;
                end
            end
            default: begin
                rd_st_d = scc_pkg::SCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            rd_st_q <= scc_pkg::SCC_IDLE;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `SCC_RESP_OKAY;
        end else begin
            rd_st_q <= rd_st_d;
            if (rd_go) begin
                rdata_q <= rdata_d;
                rresp_q <= rresp_d;
            end
        end
    end

    assign O_RVALID = (rd_st_q == scc_pkg::SCC_RESP);
    assign O_RDATA = rdata_q;
    assign O_RRESP = rresp_q;

endmodule
`default_nettype wire

// ===== bench/scc_asserts.sv
// Bus and channel output checks of the channel config bank.
// Assumes binding to scc_top; one clock, synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "scc_cfg.svh"

module scc_asserts (
    input wire logic        I_CLK,
    input wire logic        I_RST_B,
    input wire logic [31:0] I_AWADDR,
    input wire logic        I_AWVALID,
    input wire logic        O_AWREADY,
    input wire logic        I_WVALID,
    input wire logic        O_WREADY,
    input wire logic [1:0]  O_BRESP,
    input wire logic        O_BVALID,
    input wire logic [31:0] I_ARADDR,
    input wire logic        I_ARVALID,
    input wire logic        O_ARREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic [1:0]  O_RRESP,
    input wire logic        O_RVALID,
    input wire logic [3:0]  O_CHAN_RESET,
    input wire logic [3:0]  O_CHAN_TEST,
    input wire logic        O_IRQ
);
    // ======================================================================
    // Helpers
    wire logic wr_fire = I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
    wire logic chan_wr = I_AWADDR inside {`SCC_ADDR_CH_AC, `SCC_ADDR_CH_AD,
        `SCC_ADDR_CH_BC, `SCC_ADDR_CH_BD};
    wire logic chan_rd = I_ARADDR inside {`SCC_ADDR_CH_AC, `SCC_ADDR_CH_AD,
        `SCC_ADDR_CH_BC, `SCC_ADDR_CH_BD};

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);

    sequence s_wr_taken;
        wr_fire;
    endsequence
    sequence s_rd_taken;
        I_ARVALID && O_ARREADY;
    endsequence

    // ======================================================================
    // Properties
    a_write_answer: assert property (s_wr_taken |=> O_BVALID)
        else $error("no write response after write taken");
    a_read_answer: assert property (s_rd_taken |=> O_RVALID)
        else $error("no read response after read taken");
    a_chan_wr_ok: assert property (
        s_wr_taken ##0 chan_wr |=> O_BRESP == `SCC_RESP_OKAY)
        else $error("channel write refused");
    a_unused_zero: assert property (
        s_rd_taken ##0 chan_rd |=> O_RDATA[31:8] == 24'h0
            && O_RDATA[6:3] == 4'h0)
        else $error("unused channel bits read nonzero");
    a_slverr_data: assert property (
        O_RVALID && O_RRESP == `SCC_RESP_SLVERR |-> O_RDATA == 32'h0)
        else $error("refused read returns data");
    a_reset_outputs: assert property (disable iff (1'b0)
        !I_RST_B |=> O_CHAN_RESET == 4'hf && O_CHAN_TEST == 4'h0
            && !O_IRQ && !O_BVALID && !O_RVALID)
        else $error("outputs wrong during reset");
    a_reset_release: assert property (disable iff (1'b0)
        !I_RST_B ##1 I_RST_B |=> O_CHAN_RESET == 4'h0)
        else $error("channels still in reset after release");
    a_test_change: assert property (
        $changed(O_CHAN_TEST) |-> $past(wr_fire, 2) || !$past(I_RST_B))
        else $error("test mode changed without a write");
endmodule

bind scc_top scc_asserts u_chk (.I_CLK, .I_RST_B, .I_AWADDR, .I_AWVALID,
    .O_AWREADY, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_ARADDR,
    .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP, .O_RVALID, .O_CHAN_RESET,
    .O_CHAN_TEST, .O_IRQ);

`default_nettype wire

// ===== bench/serdes_channel_common_config_bench.sv
// Self-checking bench of the channel config bank over AXI4-Lite.
// Assumes scc_top and the bound checker; 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "scc_cfg.svh"

module serdes_channel_common_config_bench;
    logic        I_CLK = 1'b0;
    logic        I_RST_B = 1'b0;
    logic [31:0] I_AWADDR = 32'h0, I_WDATA = 32'h0, I_ARADDR = 32'h0;
    logic [2:0]  I_AWPROT = 3'h0, I_ARPROT = 3'h0;
    logic [3:0]  I_WSTRB = 4'h0, I_ALARM = 4'h0;
    logic        I_AWVALID = 1'b0, I_WVALID = 1'b0, I_BREADY = 1'b0;
    logic        I_ARVALID = 1'b0, I_RREADY = 1'b0;
    logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_IRQ;
    logic [1:0]  O_BRESP, O_RRESP;
    logic [31:0] O_RDATA;
    logic [3:0]  O_CHAN_RESET, O_CHAN_TEST;
    logic [4:0]  O_TEST_PATTERN_SELECT_A, O_TEST_PATTERN_SELECT_B;
    logic [31:0] ch_addr [4] = '{`SCC_ADDR_CH_AC, `SCC_ADDR_CH_AD,
        `SCC_ADDR_CH_BC, `SCC_ADDR_CH_BD};
    logic [31:0] blk_addr [2] = '{`SCC_ADDR_BLK_A, `SCC_ADDR_BLK_B};
    int          failures = 0;
    int          tests_run = 0;

    scc_top dut (.I_CLK, .I_RST_B, .I_AWADDR, .I_AWPROT, .I_AWVALID,
        .O_AWREADY, .I_WDATA, .I_WSTRB, .I_WVALID, .O_WREADY, .O_BRESP,
        .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARPROT, .I_ARVALID, .O_ARREADY,
        .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY, .I_ALARM, .O_CHAN_RESET,
        .O_CHAN_TEST, .O_TEST_PATTERN_SELECT_A, .O_TEST_PATTERN_SELECT_B,
        .O_IRQ);

    always #10 I_CLK = ~I_CLK;

    // ======================================================================
    // Shared tasks
    task automatic test_done;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s seen %h want %h", $time, msg,
                seen, exp);
        end
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        int n;
        n = 0;
        I_AWADDR <= a;
        I_WDATA <= d;
        I_WSTRB <= 4'hf;
        I_AWVALID <= 1'b1;
        I_WVALID <= 1'b1;
        I_BREADY <= 1'b1;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_AWREADY !== 1'b1 && n < 40);
        I_AWVALID <= 1'b0;
        I_WVALID <= 1'b0;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_BVALID !== 1'b1 && n < 40);
        I_BREADY <= 1'b0;
        if (n >= 40) begin
            failures++;
            test_done();
        end
        chk(O_BRESP, er, "write response");
        @(posedge I_CLK);
    endtask

    task automatic axi_rd(input logic [31:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        int n;
        n = 0;
        I_ARADDR <= a;
        I_ARVALID <= 1'b1;
        I_RREADY <= 1'b1;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_ARREADY !== 1'b1 && n < 40);
        I_ARVALID <= 1'b0;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_RVALID !== 1'b1 && n < 40);
        I_RREADY <= 1'b0;
        if (n >= 40) begin
            failures++;
            test_done();
        end
        chk(O_RDATA, d, "read data");
        chk(O_RRESP, er, "read response");
        @(posedge I_CLK);
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_reset;
        chk(O_CHAN_RESET, 4'h0, "reset release");
        chk(O_CHAN_TEST, 4'h0, "test after reset");
        for (int i = 0; i < 4; i++) begin
            axi_rd(ch_addr[i], 32'h2, `SCC_RESP_OKAY);
        end
    endtask

    task automatic t_chan;
        for (int i = 0; i < 4; i++) begin
            axi_wr(ch_addr[i], 32'hfe, `SCC_RESP_OKAY);
            axi_rd(ch_addr[i], 32'h86, `SCC_RESP_OKAY);
            chk(O_CHAN_RESET, 4'h1 << i, "soft reset");
            chk(O_CHAN_TEST, 4'h1 << i, "channel test");
            axi_wr(ch_addr[i], 32'h02, `SCC_RESP_OKAY);
            chk(O_CHAN_RESET, 4'h0, "soft reset release");
            chk(O_CHAN_TEST, 4'h0, "channel test off");
        end
    endtask

    task automatic t_block;
        for (int b = 0; b < 2; b++) begin
            axi_wr(blk_addr[b], 32'h1584, `SCC_RESP_OKAY);
            chk(O_CHAN_TEST, 4'h3 << (2 * b), "block test");
            chk(O_CHAN_RESET, 4'h3 << (2 * b), "block reset");
            chk(b ? O_TEST_PATTERN_SELECT_B : O_TEST_PATTERN_SELECT_A,
                5'h15, "pattern select");
            axi_rd(ch_addr[2 * b], 32'h2, `SCC_RESP_OKAY);
            axi_wr(blk_addr[b], 32'h0002, `SCC_RESP_OKAY);
            chk(O_CHAN_TEST, 4'h0, "block test off");
        end
    endtask

    task automatic t_alarm;
        axi_wr(`SCC_ADDR_IRQ_EN, 32'hf, `SCC_RESP_OKAY);
        I_ALARM <= 4'hf;
        axi_wr(blk_addr[0], 32'h0, `SCC_RESP_OKAY);
        repeat (3) @(posedge I_CLK);
        chk(O_IRQ, 1'b0, "channel blocked");
        axi_rd(`SCC_ADDR_STATUS, 32'h0, `SCC_RESP_OKAY);
        axi_wr(ch_addr[0], 32'h0, `SCC_RESP_OKAY);
        repeat (3) @(posedge I_CLK);
        chk(O_IRQ, 1'b1, "alarm passes");
        axi_rd(`SCC_ADDR_STATUS, 32'h1, `SCC_RESP_OKAY);
        axi_wr(`SCC_ADDR_STATUS, 32'h1, `SCC_RESP_OKAY);
        axi_rd(`SCC_ADDR_STATUS, 32'h1, `SCC_RESP_OKAY);
        axi_wr(`SCC_ADDR_IRQ_EN, 32'h0, `SCC_RESP_OKAY);
        repeat (2) @(posedge I_CLK);
        chk(O_IRQ, 1'b0, "irq disabled");
        axi_wr(blk_addr[0], 32'h2, `SCC_RESP_OKAY);
        axi_wr(`SCC_ADDR_STATUS, 32'hf, `SCC_RESP_OKAY);
        axi_wr(`SCC_ADDR_IRQ_EN, 32'hf, `SCC_RESP_OKAY);
        repeat (3) @(posedge I_CLK);
        axi_rd(`SCC_ADDR_STATUS, 32'h0, `SCC_RESP_OKAY);
        chk(O_IRQ, 1'b0, "block blocked");
        I_ALARM <= 4'h0;
    endtask

    task automatic t_unmapped;
        axi_wr(32'h0003_0300, 32'hff, `SCC_RESP_SLVERR);
        axi_rd(32'h0003_0300, 32'h0, `SCC_RESP_SLVERR);
        axi_rd(ch_addr[3], 32'h2, `SCC_RESP_OKAY);
    endtask

    initial begin
        repeat (3) @(posedge I_CLK);
        chk(O_CHAN_RESET, 4'hf, "device reset");
        I_RST_B <= 1'b1;
        @(posedge I_CLK);
        @(posedge I_CLK);
        t_reset();
        t_chan();
        t_block();
        t_alarm();
        t_unmapped();
        test_done();
    end
endmodule

`default_nettype wire
